// File: core/portd_override.sv
// Functional notes
// - Bit 7 drives timer 2 match A output
// - Bit 6 drives timer 2 match B output
// - Bit 5 drives timer 1 match A output
// - Bit 4 drives timer 1 match B output
// - Bit 6 input feeds capture and source 30
// - Upper bits: no pull-up or direction override
// - Pin change keeps input enabled, sources 24-31
// - Serial 1 transmit forces bit 3 output
// - Serial 0 transmit forces bit 1 output
// - Serial 1 receive forces bit 2 input
// - Serial 0 receive forces bit 0 input
// - Receive pull-up follows data bit, global off
// - Bit 3 input kept for interrupt one
// - Bit 2 input kept for interrupt zero
// - Two-wire mode: slew control, spike filters
// - Global pull-up off kills every pull-up
module portd_override
  import portd_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire periph_ctl_t ctl,
  output periph_in_t       fin,
  input  wire logic [7:0]  pin_in,
  output logic [7:0]       pin_out,
  output logic [7:0]       pin_oe,
  output logic [7:0]       pin_pullup,
  output logic [1:0]       slew_ctrl,
  output logic             irq
);

  // Write channel states
  typedef enum logic {W_COLLECT, W_RESP} wstate_t;

  // Software registers
  logic [7:0] port_data;          // Output value and pull-up request
  logic [7:0] port_dir;           // One means output
  logic [7:0] pc_mask;            // Pin-change source enables
  logic [7:0] irq_stat;           // Sticky pin-change events
  logic [7:0] irq_mask;           // Interrupt gate, same layout
  logic       global_pullup_off;  // Disables all pull-ups
  logic       pinchange_group3_on; // Group enable for sources

  // Synchronised pin levels
  logic [7:0] pin_sync_q;

  // Override vectors, one bit per pin
  logic [7:0] pullup_override_enable;
  logic [7:0] pullup_value_override;
  logic [7:0] direction_override_enable;
  logic [7:0] direction_override_value;
  logic [7:0] port_value_override_enable;
  logic [7:0] port_value_override_value;
  logic [7:0] input_enable_override_enable;
  logic [7:0] input_enable_override_value;

  // Resolved pin controls
  logic [7:0] eff_pu;
  logic [7:0] eff_dir;
  logic [7:0] eff_val;
  logic [7:0] eff_die;
  logic [7:0] pin_input_to_function; // Gated digital input

  // Pin-change tracking
  logic [7:0] pin_prev;           // Last gated input
  logic [7:0] pc_event;           // One-cycle change pulses

  // Two-wire spike filters
  logic [1:0] filt;               // Filtered levels
  logic [1:0] spike_cnt [2];      // Cycles the input differed

  // Write path
  wstate_t    wst;
  logic       have_aw;            // Address already taken
  logic       have_w;             // Data already taken
  logic [7:0] waddr_q;
  logic [7:0] wbyte_q;
  logic       wlane_q;            // Strobe of the low byte lane
  logic       aw_hit;
  logic       w_hit;
  logic       do_write;
  logic [7:0] wr_addr;
  logic [7:0] wr_byte;
  logic       wr_lane;
  logic       wen_data;
  logic       wen_dir;
  logic       wen_ctrl;
  logic       wen_pcmask;
  logic       wen_stat;
  logic       wen_mask;
  logic [7:0] stat_clr;           // Write-one-to-clear bits

  // Read path
  logic       ar_hit;
  logic [7:0] rd_byte;

  // Picks override value over the register-derived default
  function automatic logic pick(input logic en, input logic val,
                                input logic dflt);
    return en ? val : dflt;
  endfunction

  // Address map check, used by both the read and write paths
  function automatic logic is_mapped(input logic [7:0] a);
    return a == OFS_DATA || a == OFS_DIR || a == OFS_PIN ||
           a == OFS_CTRL || a == OFS_PCMASK || a == OFS_STAT ||
           a == OFS_MASK;
  endfunction

  // Pins come from outside the clock domain
  pin_sync #(.WIDTH(8)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       (pin_in),
    .q       (pin_sync_q)
  );

  // Pull-up overrides: only the serial pins on bits 3 to 0
  assign pullup_override_enable = {4'h0, ctl.serial1_tx_on,
                                   ctl.serial1_rx_on, ctl.serial0_tx_on,
                                   ctl.serial0_rx_on};
  // Receivers keep software control of the pull-up
  assign pullup_value_override =
    {5'h00, port_data[2] & ~global_pullup_off, 1'b0,
     port_data[0] & ~global_pullup_off};

  // Direction: transmit forces output, receive forces input
  assign direction_override_enable = pullup_override_enable;
  assign direction_override_value  = 8'h0a;

  // Output value: compare units above, transmit data below
  assign port_value_override_enable =
    {ctl.timer2_match_a_en, ctl.timer2_match_b_en,
     ctl.timer1_match_a_en, ctl.timer1_match_b_en,
     ctl.serial1_tx_on, 1'b0, ctl.serial0_tx_on, 1'b0};
  assign port_value_override_value =
    {ctl.timer2_match_a_out, ctl.timer2_match_b_out,
     ctl.timer1_match_a_out, ctl.timer1_match_b_out,
     ctl.serial1_tx_line, 1'b0, ctl.serial0_tx_line, 1'b0};

  // Input stays enabled for pin change and external interrupts
  assign input_enable_override_enable =
    (pc_mask & {8{pinchange_group3_on}}) |
    {4'h0, ctl.ext_irq_one_on, ctl.ext_irq_zero_on, 2'h0};
  assign input_enable_override_value = 8'hff;

  // Per-pin resolution of every override type
  for (genvar i = 0; i < 8; i++) begin : g_pin
    // Plain port pull-up needs input, data one, global enable
    assign eff_pu[i]  = pick(pullup_override_enable[i],
                             pullup_value_override[i],
                             ~port_dir[i] & port_data[i] &
                             ~global_pullup_off);
    assign eff_dir[i] = pick(direction_override_enable[i],
                             direction_override_value[i], port_dir[i]);
    assign eff_val[i] = pick(port_value_override_enable[i],
                             port_value_override_value[i], port_data[i]);
    // Input is always enabled: default and override value are both one
    assign eff_die[i] = pick(input_enable_override_enable[i],
                             input_enable_override_value[i], 1'b1);
    assign pin_input_to_function[i] = pin_sync_q[i] & eff_die[i];
  end

  // Change detection, qualified by source mask and group enable
  assign pc_event = (pin_input_to_function ^ pin_prev) & pc_mask &
                    {8{pinchange_group3_on}};

  // Pin drivers and peripheral inputs are registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out    <= '0;
      pin_oe     <= '0;
      pin_pullup <= '0;
      slew_ctrl  <= '0;
      pin_prev   <= '0;
    end else if (ce) begin
      // A compare output only reaches the pad when it is an output
      pin_out    <= eff_val;
      pin_oe     <= eff_dir;
      pin_pullup <= eff_pu;
      slew_ctrl  <= {2{ctl.two_wire_on}};
      pin_prev   <= pin_input_to_function;
    end
  end

  // Route gated inputs to the consuming peripherals
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fin <= '0;
    end else if (ce) begin
      fin.timer1_capture_in <= pin_input_to_function[6];
      fin.serial0_rx_line   <= pin_input_to_function[0];
      fin.serial1_rx_line   <= pin_input_to_function[2];
      fin.ext_irq_zero_in   <= pin_input_to_function[2];
      fin.ext_irq_one_in    <= pin_input_to_function[3];
      fin.pinchange_src     <= pin_input_to_function;
      fin.two_wire_in       <= filt;
    end
  end

  // Spike filters on bits 1 and 0 for the two-wire unit
  for (genvar j = 0; j < 2; j++) begin : g_filt
    // A level must hold for the spike time before it passes;
    // this costs one cycle fewer than that of delay on every edge
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        filt[j]      <= 1'b0;
        spike_cnt[j] <= '0;
      end else if (ce) begin
        if (!ctl.two_wire_on) begin
          // Filter bypassed
          filt[j]      <= pin_sync_q[j];
          spike_cnt[j] <= '0;
        end else if (pin_sync_q[j] == filt[j]) begin
          // Blip ended, forget it
          spike_cnt[j] <= '0;
        end else if (spike_cnt[j] == SPIKE_LIM - 2'h1) begin
          filt[j]      <= pin_sync_q[j];
          spike_cnt[j] <= '0;
        end else begin
          spike_cnt[j] <= spike_cnt[j] + 2'h1;
        end
      end
    end
  end

  // Bus handshakes and decode
  assign awready  = (wst == W_COLLECT) && !have_aw;
  assign wready   = (wst == W_COLLECT) && !have_w;
  assign aw_hit   = awvalid && awready;
  assign w_hit    = wvalid && wready;
  assign do_write = (wst == W_COLLECT) && (have_aw || aw_hit) &&
                    (have_w || w_hit);
  assign wr_addr  = have_aw ? waddr_q : awaddr;
  assign wr_byte  = have_w ? wbyte_q : wdata[7:0];
  assign wr_lane  = have_w ? wlane_q : wstrb[0];
  assign bvalid   = (wst == W_RESP);
  assign arready  = !rvalid;
  assign ar_hit   = arvalid && arready;

  // Register write enables; upper byte lanes hold nothing
  assign wen_data   = do_write && wr_lane && wr_addr == OFS_DATA;
  assign wen_dir    = do_write && wr_lane && wr_addr == OFS_DIR;
  assign wen_ctrl   = do_write && wr_lane && wr_addr == OFS_CTRL;
  assign wen_pcmask = do_write && wr_lane && wr_addr == OFS_PCMASK;
  assign wen_stat   = do_write && wr_lane && wr_addr == OFS_STAT;
  assign wen_mask   = do_write && wr_lane && wr_addr == OFS_MASK;
  assign stat_clr   = wen_stat ? wr_byte : 8'h00;

  // Write channel: address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst     <= W_COLLECT;
      have_aw <= 1'b0;
      have_w  <= 1'b0;
      waddr_q <= '0;
      wbyte_q <= '0;
      wlane_q <= 1'b0;
      bresp   <= RESP_OKAY;
    end else if (ce) begin
      case (wst)
        W_COLLECT: begin
          if (aw_hit) begin
            have_aw <= 1'b1;
            waddr_q <= awaddr;
          end
          if (w_hit) begin
            have_w  <= 1'b1;
            wbyte_q <= wdata[7:0];
            wlane_q <= wstrb[0];
          end
          if (do_write) begin
            wst     <= W_RESP;
            have_aw <= 1'b0;
            have_w  <= 1'b0;
            bresp   <= is_mapped(wr_addr) ? RESP_OKAY : RESP_DECERR;
          end
        end
        W_RESP: begin
          if (bready) begin
            wst <= W_COLLECT;
          end
        end
        default: begin
          wst <= W_COLLECT;
        end
      endcase
    end
  end

  // Software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_data           <= RST_BYTE;
      port_dir            <= RST_BYTE;
      pc_mask             <= RST_BYTE;
      irq_mask            <= RST_BYTE;
      global_pullup_off   <= 1'b0;
      pinchange_group3_on <= 1'b0;
    end else if (ce) begin
      if (wen_data) begin
        port_data <= wr_byte;
      end
      if (wen_dir) begin
        port_dir <= wr_byte;
      end
      if (wen_pcmask) begin
        pc_mask <= wr_byte;
      end
      if (wen_mask) begin
        irq_mask <= wr_byte;
      end
      if (wen_ctrl) begin
        global_pullup_off   <= wr_byte[CTRL_PULLUP_OFF];
        pinchange_group3_on <= wr_byte[CTRL_GROUP3_ON];
      end
    end
  end

  // Sticky events: a new event beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= RST_BYTE;
    end else if (ce) begin
      irq_stat <= (irq_stat & ~stat_clr) | pc_event;
    end
  end

  // Level interrupt from flip-flops only
  assign irq = |(irq_stat & irq_mask);

  // Read data selection
  assign rd_byte =
    (araddr == OFS_DATA)   ? port_data :
    (araddr == OFS_DIR)    ? port_dir :
    (araddr == OFS_PIN)    ? pin_sync_q :
    (araddr == OFS_CTRL)   ? {6'h00, pinchange_group3_on,
                              global_pullup_off} :
    (araddr == OFS_PCMASK) ? pc_mask :
    (araddr == OFS_STAT)   ? irq_stat :
    (araddr == OFS_MASK)   ? irq_mask : 8'h00;

  // Read channel: one read at a time, data held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (ar_hit) begin
        rvalid <= 1'b1;
        rdata  <= {24'h000000, rd_byte};
        rresp  <= is_mapped(araddr) ? RESP_OKAY : RESP_DECERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Checks on the registered pin and peripheral paths
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A one-cycle blip on the two-wire data input
  sequence s_tw_blip;
    ce && ctl.two_wire_on && pin_sync_q[0] == filt[0] ##1
    ce && ctl.two_wire_on && pin_sync_q[0] != filt[0] ##1
    ce && ctl.two_wire_on && pin_sync_q[0] == filt[0];
  endsequence

  chk_t2a_pin_value: assert property (
    ce && ctl.timer2_match_a_en |=>
      pin_out[7] == $past(ctl.timer2_match_a_out) &&
      pin_oe[7] == $past(port_dir[7]))
    else $error("bit 7 not carrying timer 2 match A");
  chk_t2b_pin_value: assert property (
    ce && ctl.timer2_match_b_en |=>
      pin_out[6] == $past(ctl.timer2_match_b_out))
    else $error("bit 6 not carrying timer 2 match B");
  chk_t1a_pin_value: assert property (
    ce && ctl.timer1_match_a_en |=>
      pin_out[5] == $past(ctl.timer1_match_a_out))
    else $error("bit 5 not carrying timer 1 match A");
  chk_t1b_pin_value: assert property (
    ce && ctl.timer1_match_b_en |=>
      pin_out[4] == $past(ctl.timer1_match_b_out))
    else $error("bit 4 not carrying timer 1 match B");
  chk_capture_route: assert property (
    ce |=> fin.timer1_capture_in == $past(pin_sync_q[6]) &&
      fin.pinchange_src[6] == $past(pin_sync_q[6]))
    else $error("capture input or source 30 not following bit 6");
  chk_upper_dir_plain: assert property (
    ce |=> pin_oe[7:4] == $past(port_dir[7:4]))
    else $error("upper bits direction overridden");
  chk_pc_input_kept: assert property (
    ce && pc_mask[5] && pinchange_group3_on |=>
      fin.pinchange_src[5] == $past(pin_sync_q[5]))
    else $error("pin change input not kept enabled");
  chk_tx1_forces_out: assert property (
    ce && ctl.serial1_tx_on |=> pin_oe[3] && !pin_pullup[3] &&
      pin_out[3] == $past(ctl.serial1_tx_line))
    else $error("serial 1 transmit not forcing bit 3");
  chk_tx0_forces_out: assert property (
    ce && ctl.serial0_tx_on |=> pin_oe[1] && !pin_pullup[1] &&
      pin_out[1] == $past(ctl.serial0_tx_line))
    else $error("serial 0 transmit not forcing bit 1");
  chk_rx1_forces_in: assert property (
    ce && ctl.serial1_rx_on |=> !pin_oe[2] &&
      fin.serial1_rx_line == $past(pin_sync_q[2]))
    else $error("serial 1 receive not forcing bit 2");
  chk_rx0_forces_in: assert property (
    ce && ctl.serial0_rx_on |=> !pin_oe[0] &&
      fin.serial0_rx_line == $past(pin_sync_q[0]))
    else $error("serial 0 receive not forcing bit 0");
  chk_rx_pullup_soft: assert property (
    ce && ctl.serial0_rx_on |=>
      pin_pullup[0] == ($past(port_data[0]) & ~$past(global_pullup_off)))
    else $error("receive pull-up not under software");
  chk_irq1_input_on: assert property (
    ce && ctl.ext_irq_one_on |=>
      fin.ext_irq_one_in == $past(pin_sync_q[3]))
    else $error("interrupt one input gated off");
  chk_irq0_input_on: assert property (
    ce && ctl.ext_irq_zero_on |=>
      fin.ext_irq_zero_in == $past(pin_sync_q[2]))
    else $error("interrupt zero input gated off");
  chk_tw_spike_block: assert property (
    s_tw_blip |-> $stable(filt[0]))
    else $error("two-wire spike passed the filter");
  chk_pullup_off_all: assert property (
    ce && global_pullup_off |=> pin_pullup == 8'h00)
    else $error("pull-up active while globally off");
  chk_default_value: assert property (
    ce && !ctl.timer2_match_a_en |=> pin_out[7] == $past(port_data[7]))
    else $error("bit 7 not following port data");

endmodule // portd_override

// File: core/portd_pkg.sv
package portd_pkg;

  // Clock rate of the I/O clock, in MHz
  localparam int CLK_MHZ = 40;
  // Shortest pulse that the two-wire input filters pass, in ns
  localparam int SPIKE_NS = 50;
  // Least time rounds up to whole cycles
  localparam int SPIKE_CYC = (SPIKE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] SPIKE_LIM = 2'(SPIKE_CYC);

  // Register byte addresses, one aligned word each
  localparam logic [7:0] OFS_DATA   = 8'h00;
  localparam logic [7:0] OFS_DIR    = 8'h04;
  localparam logic [7:0] OFS_PIN    = 8'h08;
  localparam logic [7:0] OFS_CTRL   = 8'h0c;
  localparam logic [7:0] OFS_PCMASK = 8'h10;
  localparam logic [7:0] OFS_STAT   = 8'h14;
  localparam logic [7:0] OFS_MASK   = 8'h18;

  // Field positions in the control register
  localparam int CTRL_PULLUP_OFF = 0;
  localparam int CTRL_GROUP3_ON  = 1;

  // Reset value of every byte register
  localparam logic [7:0] RST_BYTE = 8'h00;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Controls arriving from timers, serial ports and interrupt logic
  typedef struct packed {
    logic timer2_match_a_en;
    logic timer2_match_a_out;
    logic timer2_match_b_en;
    logic timer2_match_b_out;
    logic timer1_match_a_en;
    logic timer1_match_a_out;
    logic timer1_match_b_en;
    logic timer1_match_b_out;
    logic serial1_tx_on;
    logic serial1_tx_line;
    logic serial0_tx_on;
    logic serial0_tx_line;
    logic serial1_rx_on;
    logic serial0_rx_on;
    logic ext_irq_zero_on;
    logic ext_irq_one_on;
    logic two_wire_on;
  } periph_ctl_t;

  // Pin levels delivered to the peripherals
  typedef struct packed {
    logic       timer1_capture_in;
    logic       serial0_rx_line;
    logic       serial1_rx_line;
    logic       ext_irq_zero_in;
    logic       ext_irq_one_in;
    logic [7:0] pinchange_src;
    logic [1:0] two_wire_in;
  } periph_in_t;

endpackage

// File: core/pin_sync.sv
module pin_sync
  import portd_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // First stage may go metastable; only the second stage reads it
  logic [WIDTH-1:0] meta;

  // Two-flop synchroniser, frozen with the clock enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // pin_sync

// File: tb/periph_model.sv
module periph_model
  import portd_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [16:0] req,
  input  wire periph_in_t  fin,
  output periph_ctl_t      ctl,
  output logic             cap_seen
);
  timeunit 1ns;
  timeprecision 100ps;

  // Peripheral controls move just after an edge, as real timers do
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl <= '0;
    end else begin
      ctl <= req;
    end
  end

  // Capture trigger as the timer samples it, one edge late
  always_ff @(posedge aclk) begin
    cap_seen <= fin.timer1_capture_in;
  end
endmodule // periph_model

// File: tb/port_d_alt_function_override_tb.sv
module port_d_alt_function_override_tb
  import portd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        aclk = 0;        // 40 MHz bus clock
  logic        aresetn = 0;     // Synchronous reset
  logic        ce = 1;          // Clock enable, low only in the clock enable test
  logic        awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq, cap_seen;
  logic [7:0]  awaddr = 0, araddr = 0, pin_in = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0]  bresp, rresp, slew_ctrl;
  logic [7:0]  pin_out, pin_oe, pin_pullup;
  logic [16:0] req = 0;         // Wanted peripheral controls
  periph_ctl_t ctl;
  periph_in_t  fin;
  int          n_fail = 0, cmp_count = 0;
  logic [1:0]  resp;            // Last bus response
  logic [31:0] rd;              // Last read data
  logic [64:0] r;               // Current table row

  // Row: ctl, dir, data, ctrl | expected oe, out, pull-up
  localparam logic [64:0] ROWS [8] = '{
    {17'h1fe00, 8'hf0, 8'h00, 8'h00, 8'hf0, 8'hf0, 8'h00},
    {17'h15400, 8'hf0, 8'hf0, 8'h00, 8'hf0, 8'h00, 8'h00},
    {17'h1fe00, 8'h00, 8'hf0, 8'h00, 8'h00, 8'hf0, 8'hf0},
    {17'h001c0, 8'h00, 8'h0a, 8'h00, 8'h0a, 8'h08, 8'h00},
    {17'h00018, 8'h05, 8'h05, 8'h00, 8'h00, 8'h05, 8'h05},
    {17'h00018, 8'h05, 8'h05, 8'h01, 8'h00, 8'h05, 8'h00},
    {17'h00000, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff},
    {17'h00000, 8'h00, 8'hff, 8'h01, 8'h00, 8'hff, 8'h00}};

  always #12.5 aclk = ~aclk;

  portd_override i_portd_override (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .ctl(ctl), .fin(fin), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup), .slew_ctrl(slew_ctrl),
    .irq(irq));

  periph_model i_periph_model (
    .aclk(aclk), .aresetn(aresetn), .req(req), .fin(fin), .ctl(ctl),
    .cap_seen(cap_seen));

  // Compare and count; an unknown never matches
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("Error at %0t: got %h want %h", $time, s, e);
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw;
    ta = 0;
    tw = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ta = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        tw = 1;
        wvalid <= 0;
      end
    end while (!(ta && tw));
    // Ready raised only now, so a following call never lowers and
    // raises it in one time step
    bready <= 1;
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 0;
  endtask

  // Read: address held until taken, rready held until data seen
  task automatic rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    rready <= 1;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 0;
  endtask

  // Single place where the run ends
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog: the whole run needs well under this many cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    // Every register reads zero after reset
    for (int a = 0; a <= 24; a += 4) begin
      rdr(8'(a));
      chk(rd, 32'h0);
    end
    $display("reset values done");
    // Table of override cases, one settle time per row
    foreach (ROWS[i]) begin
      r = ROWS[i];
      wr(OFS_DIR, r[47:40]);
      wr(OFS_DATA, r[39:32]);
      wr(OFS_CTRL, r[31:24]);
      req <= r[64:48];
      repeat (3) @(posedge aclk);
      chk(32'(pin_oe), 32'(r[23:16]));
      chk(32'(pin_out), 32'(r[15:8]));
      chk(32'(pin_pullup), 32'(r[7:0]));
    end
    $display("override table done");
    // Pad levels reach every peripheral input within four edges
    req <= '0;
    wr(OFS_CTRL, 8'h00);
    pin_in <= 8'h45;
    repeat (5) @(posedge aclk);
    chk(32'(fin), {17'h0, 15'h7915});
    chk(32'(cap_seen), 32'h1);
    rdr(OFS_PIN);
    chk(rd, 32'h45);
    $display("input routing done");
    // Pin change on bit 6 sets status; mask gates the interrupt
    wr(OFS_PCMASK, 8'h40);
    wr(OFS_CTRL, 8'h02);
    pin_in <= 8'h05;
    repeat (5) @(posedge aclk);
    chk(32'(irq), 32'h0);
    rdr(OFS_STAT);
    chk(rd, 32'h40);
    wr(OFS_MASK, 8'h40);
    chk(32'(resp), 32'(RESP_OKAY));
    @(posedge aclk);
    chk(32'(irq), 32'h1);
    wr(OFS_STAT, 8'h40);
    @(posedge aclk);
    chk(32'(irq), 32'h0);
    rdr(OFS_STAT);
    chk(rd, 32'h0);
    $display("interrupt done");
    // Unmapped place: decode error, reads zero
    wr(8'h1c, 8'hff);
    chk(32'(resp), 32'(RESP_DECERR));
    rdr(8'h1c);
    chk(rd, 32'h0);
    chk(32'(resp), 32'(RESP_DECERR));
    $display("unmapped done");
    // Two-wire mode turns on slew control of bits 1 and 0
    req <= 17'h00001;
    repeat (3) @(posedge aclk);
    chk(32'(slew_ctrl), 32'h3);
    // One-cycle dip on bit 0 is filtered out
    pin_in <= 8'h04;
    @(posedge aclk);
    pin_in <= 8'h05;
    repeat (6) begin
      @(negedge aclk);
      chk(32'(fin.two_wire_in[0]), 32'h1);
    end
    // A held low passes one cycle later than unfiltered
    @(posedge aclk);
    pin_in <= 8'h04;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk(32'(fin.two_wire_in[0]), 32'h1);
    @(negedge aclk);
    chk(32'(fin.two_wire_in[0]), 32'h0);
    @(posedge aclk);
    $display("two-wire done");
    // Clock enable low freezes the pin drivers
    ce <= 0;
    req <= 17'h00100;
    repeat (3) @(posedge aclk);
    chk(32'(pin_oe), 32'h0);
    ce <= 1;
    repeat (3) @(posedge aclk);
    chk(32'(pin_oe), 32'h08);
    $display("clock enable done");
    // Reset in mid-run returns registers and pin drivers to zero
    req <= '0;
    wr(OFS_DIR, 8'hff);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    @(negedge aclk);
    chk({pin_oe, pin_out, pin_pullup, 6'h0, slew_ctrl}, 32'h0);
    chk(32'(fin), 32'h0);
    chk(32'(irq), 32'h0);
    @(posedge aclk);
    rdr(OFS_DIR);
    chk(rd, 32'h0);
    $display("mid-run reset done");
    test_done();
  end
endmodule // port_d_alt_function_override_tb
